// ---- verilog/dcts_seq.sv ----
// Four-channel DMA transfer sequencer with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module dcts_seq #(
    parameter int BC_W = 24 // Byte count width
)
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic [31:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic [dcts_pkg::NCH-1:0] external_transfer_request_n, // Request pins
    output logic dbus_breq, // Bus request to arbiter
    input wire logic dbus_gnt, // Bus grant
    output logic dbus_valid, // Access in progress
    output dcts_pkg::dcts_cmd_t dbus_cmd, // Access command
    input wire logic [31:0] dbus_rdata, // Read data
    input wire logic dbus_ack, // Access done
    input wire logic dbus_err // Access failed
);
    import dcts_pkg::*;

    // ==========================================================
    // Per-channel state, then shared engine and slave-port state
    logic [31:0] ctrl_r [NCH];
    logic [31:0] sar_r [NCH];
    logic [31:0] dar_r [NCH];
    logic [BC_W-1:0] bcr_r [NCH];
    logic [NCH-1:0] done_r, act_r, pend_r, bes_r, ce_r, abort_r;

    dcts_state_t st_r;
    logic [1:0] cur_r;
    logic [4:0] rem_r;
    logic [31:0] hold_r;
    logic drop_r;
    dcts_cmd_t cmd_r;

    logic dp_wr_r, dp_rd_r, dp_ok_r;
    logic [7:0] dp_addr_r;
    logic [31:0] hrdata_r, rdv;

    // ==========================================================
    // Helpers
    function automatic logic [4:0] sz_bytes(input logic [1:0] s);
        case (s)
            SZ_BYTE: sz_bytes = 5'h01;
            SZ_WORD: sz_bytes = 5'h02;
            SZ_LINE: sz_bytes = 5'h10;
            default: sz_bytes = 5'h04;
        endcase
    endfunction

    // Bytes per transfer: larger side in dual mode, source size in single
    function automatic logic [4:0] step_bytes(input logic [31:0] c);
        logic [4:0] s, d;
        s = sz_bytes(c[C_SOURCE_WIDTH_FIELD +: 2]);
        d = sz_bytes(c[C_DEST_WIDTH_FIELD +: 2]);
        if (c[C_SAA] || s > d)
            step_bytes = s;
        else
            step_bytes = d;
    endfunction

    function automatic logic misal(input logic [31:0] v, input logic [4:0] b);
        misal = |(v[3:0] & (b[3:0] - 4'h1));
    endfunction

    function automatic logic at_bound(input logic [BC_W-1:0] c, input logic [2:0] w);
        logic [31:0] m;
        m = (32'h1 << ({2'b00, w} + BWC_BASE)) - 32'h1;
        at_bound = (w != 3'h0) && (c != '0) && ((32'(c) & m) == 32'h0);
    endfunction

    // Returns {found, channel}
    function automatic logic [2:0] pick(input logic [NCH-1:0] p, input logic [NCH-1:0][2:0] bw);
        logic [1:0] rk [NCH];
        logic [1:0] best;
        logic hit;
        best = 2'h0;
        hit = 1'b0;
        for (int k = 0; k < NCH; k++)
            rk[k] = 2'(k);
        // Promotions can never overlap, so one pass is enough
        for (int k = 1; k < NCH; k++)
            if (bw[k] == 3'h0 && bw[k-1] != 3'h0)
            begin
                rk[k] = 2'(k - 1);
                rk[k-1] = 2'(k);
            end
        for (int k = 0; k < NCH; k++)
            if (p[k] && (!hit || rk[k] < rk[best]))
            begin
                best = 2'(k);
                hit = 1'b1;
            end
        pick = {hit, best};
    endfunction

    // ==========================================================
    // Engine datapath for the selected channel
    logic [31:0] cc, sar_nx, dar_nx;
    logic [4:0] sb, db, xb;
    logic [BC_W-1:0] bcr_cur, nbcr, nbcr2;
    logic acc, ok, err, last_acc, fin, stop, go_gap, sel;
    logic [2:0] pk;
    logic [NCH-1:0][2:0] bw_all;
    logic [NCH-1:0] rq, cfg_bad, sw_clr;
    logic wr_ev;
    logic [1:0] wch;
    logic [4:0] wofs;

    assign cc = ctrl_r[cur_r];
    assign sb = sz_bytes(cc[C_SOURCE_WIDTH_FIELD +: 2]);
    assign db = sz_bytes(cc[C_DEST_WIDTH_FIELD +: 2]);
    assign xb = step_bytes(cc);
    assign bcr_cur = bcr_r[cur_r];
    assign nbcr = bcr_cur - BC_W'(xb);
    assign nbcr2 = nbcr - BC_W'(xb);
    assign sar_nx = cc[C_SOURCE_INCREMENT_ENABLE] ? sar_r[cur_r] + 32'(sb) : sar_r[cur_r];
    assign dar_nx = cc[C_DEST_INCREMENT_ENABLE] ? dar_r[cur_r] + 32'(db) : dar_r[cur_r];

    assign acc = (st_r == E_RD) || (st_r == E_WR) || (st_r == E_SGL);
    assign ok = acc && dbus_ack && !dbus_err;
    assign err = acc && dbus_err;
    assign last_acc = (st_r == E_WR && rem_r == db) || st_r == E_SGL;
    assign fin = ok && last_acc;
    assign stop = fin && (nbcr == '0 || cc[C_CS] || abort_r[cur_r]);
    assign go_gap = fin && !stop && at_bound(nbcr, cc[C_BWC +: 3]);
    assign sel = st_r == E_ARB && dbus_gnt && pend_r[cur_r];
    assign pk = pick(pend_r, bw_all);

    // Request falls away during the last access before a boundary
    assign dbus_breq = st_r == E_ARB || (acc && !(last_acc && drop_r));
    assign dbus_valid = acc;
    assign dbus_cmd = cmd_r;

    always_comb
    begin
        for (int k = 0; k < NCH; k++)
        begin
            bw_all[k] = ctrl_r[k][C_BWC +: 3];
            // A done channel takes no new request until software clears it
            rq[k] = (ctrl_r[k][C_START] || (ctrl_r[k][C_EXTERNAL_REQUEST_ENABLE] && !external_transfer_request_n[k]))
                && !pend_r[k] && !act_r[k] && !done_r[k];
            cfg_bad[k] = bcr_r[k] == '0 || misal(sar_r[k], sz_bytes(ctrl_r[k][C_SOURCE_WIDTH_FIELD +: 2]))
                || (!ctrl_r[k][C_SAA] && misal(dar_r[k], sz_bytes(ctrl_r[k][C_DEST_WIDTH_FIELD +: 2])))
                || misal(32'(bcr_r[k]), step_bytes(ctrl_r[k]));
            sw_clr[k] = wr_ev && wch == 2'(k) && wofs == OFS_STAT && hwdata[S_DONE];
        end
    end

    // ==========================================================
    // Transfer sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= E_IDLE;
            cur_r <= 2'h0;
            rem_r <= 5'h00;
            hold_r <= 32'h0000_0000;
            drop_r <= 1'b0;
            cmd_r <= '0;
        end
        else if (ce)
        begin
            case (st_r)
                E_IDLE:
                begin
                    if (pk[2])
                    begin
                        cur_r <= pk[1:0];
                        st_r <= E_ARB;
                    end
                end
                E_ARB:
                begin
                    if (!pend_r[cur_r])
                        st_r <= E_IDLE;
                    else if (dbus_gnt)
                    begin
                        hold_r <= 32'h0000_0000;
                        rem_r <= xb;
                        drop_r <= at_bound(nbcr, cc[C_BWC +: 3]);
                        cmd_r.addr <= sar_r[cur_r];
                        cmd_r.size <= cc[C_SOURCE_WIDTH_FIELD +: 2];
                        cmd_r.write <= cc[C_SAA] && !cc[C_SRW];
                        cmd_r.wdata <= 32'h0000_0000;
                        st_r <= cc[C_SAA] ? E_SGL : E_RD;
                    end
                end
                E_RD:
                begin
                    if (err)
                        st_r <= E_IDLE;
                    else if (ok)
                    begin
                        hold_r <= hold_r | dbus_rdata;
                        if (rem_r == sb)
                        begin
                            rem_r <= xb;
                            cmd_r.addr <= dar_r[cur_r];
                            cmd_r.size <= cc[C_DEST_WIDTH_FIELD +: 2];
                            cmd_r.write <= 1'b1;
                            cmd_r.wdata <= hold_r | dbus_rdata;
                            st_r <= E_WR;
                        end
                        else
                        begin
                            rem_r <= rem_r - sb;
                            cmd_r.addr <= sar_nx;
                        end
                    end
                end
                E_WR, E_SGL:
                begin
                    if (err)
                        st_r <= E_IDLE;
                    else if (ok && !last_acc)
                    begin
                        rem_r <= rem_r - db;
                        cmd_r.addr <= dar_nx;
                    end
                    else if (fin)
                    begin
                        if (stop)
                            st_r <= E_IDLE;
                        else if (go_gap)
                            st_r <= E_GAP;
                        else
                        begin
                            // Continuous mode keeps the bus for the next transfer
                            hold_r <= 32'h0000_0000;
                            rem_r <= xb;
                            drop_r <= at_bound(nbcr2, cc[C_BWC +: 3]);
                            cmd_r.addr <= cc[C_SAA] ? sar_nx : sar_r[cur_r];
                            cmd_r.size <= cc[C_SOURCE_WIDTH_FIELD +: 2];
                            cmd_r.write <= cc[C_SAA] && !cc[C_SRW];
                            cmd_r.wdata <= 32'h0000_0000;
                            st_r <= cc[C_SAA] ? E_SGL : E_RD;
                        end
                    end
                end
                E_GAP:
                    st_r <= E_IDLE;
                default:
                    st_r <= E_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Control and status, one set per channel
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int c = 0; c < NCH; c++)
                ctrl_r[c] <= CTRL_RST;
            done_r <= '0;
            act_r <= '0;
            pend_r <= '0;
            bes_r <= '0;
            ce_r <= '0;
            abort_r <= '0;
        end
        else if (ce)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (sel && cur_r == 2'(c))
                    ctrl_r[c][C_START] <= 1'b0;
                if (rq[c] && cfg_bad[c])
                    ctrl_r[c][C_START] <= 1'b0;
                // No protection while active: new settings steer the next access
                if (wr_ev && wch == 2'(c) && wofs == OFS_CTRL)
                    ctrl_r[c] <= hwdata;
                if (sw_clr[c])
                begin
                    done_r[c] <= 1'b0;
                    act_r[c] <= 1'b0;
                    pend_r[c] <= 1'b0;
                    bes_r[c] <= 1'b0;
                    ce_r[c] <= 1'b0;
                    abort_r[c] <= act_r[c] || pend_r[c];
                end
                else if (st_r == E_IDLE)
                    abort_r[c] <= 1'b0;
                // Hardware events below win over a same-cycle clear
                if (rq[c])
                begin
                    if (cfg_bad[c])
                    begin
                        ce_r[c] <= 1'b1;
                        done_r[c] <= 1'b1;
                    end
                    else
                        pend_r[c] <= 1'b1;
                end
                if (cur_r == 2'(c))
                begin
                    if (sel)
                    begin
                        pend_r[c] <= 1'b0;
                        act_r[c] <= 1'b1;
                    end
                    if (go_gap)
                        pend_r[c] <= 1'b1;
                    if (err || stop)
                        act_r[c] <= 1'b0;
                    if (err)
                    begin
                        bes_r[c] <= 1'b1;
                        done_r[c] <= 1'b1;
                    end
                    if (fin && nbcr == '0)
                        done_r[c] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Address and count registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                sar_r[c] <= 32'h0000_0000;
                dar_r[c] <= 32'h0000_0000;
                bcr_r[c] <= '0;
            end
        end
        else if (ce)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (wr_ev && wch == 2'(c))
                begin
                    case (wofs)
                        OFS_SAR: sar_r[c] <= hwdata;
                        OFS_DAR: dar_r[c] <= hwdata;
                        OFS_BCR: bcr_r[c] <= hwdata[BC_W-1:0];
                        default: ;
                    endcase
                end
                if (cur_r == 2'(c))
                begin
                    if ((st_r == E_RD || st_r == E_SGL) && ok)
                        sar_r[c] <= sar_nx;
                    if (st_r == E_WR && ok)
                        dar_r[c] <= dar_nx;
                    if (fin)
                        bcr_r[c] <= nbcr;
                end
            end
        end
    end

    // ==========================================================
    // AHB-Lite slave: writes without wait, reads with one wait state
    assign wch = dp_addr_r[6:5];
    assign wofs = dp_addr_r[4:0];
    assign wr_ev = dp_wr_r && dp_ok_r;
    assign hreadyout = !dp_rd_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;

    always_comb
    begin
        rdv = 32'h0000_0000;
        if (dp_ok_r)
        begin
            case (wofs)
                OFS_CTRL: rdv = ctrl_r[wch];
                OFS_STAT:
                begin
                    rdv[S_DONE] = done_r[wch];
                    rdv[S_ACT] = act_r[wch];
                    rdv[S_REQ] = pend_r[wch];
                    rdv[S_BES] = bes_r[wch];
                    rdv[S_CE] = ce_r[wch];
                end
                OFS_SAR: rdv = sar_r[wch];
                OFS_DAR: rdv = dar_r[wch];
                OFS_BCR: rdv = 32'(bcr_r[wch]);
                default: rdv = 32'h0000_0000;
            endcase
        end
    end

    // The wait state lets a write in the previous data phase land first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_ok_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (hready)
            begin
                dp_wr_r <= hsel && htrans[1] && hwrite;
                dp_rd_r <= hsel && htrans[1] && !hwrite;
                if (hsel && htrans[1])
                begin
                    dp_addr_r <= haddr[7:0];
                    dp_ok_r <= haddr[31:7] == 25'h0 && haddr[1:0] == 2'h0 && haddr[4:0] <= OFS_BCR;
                end
            end
            else if (dp_rd_r)
            begin
                hrdata_r <= rdv;
                dp_rd_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !ce);

    a_start_self_clear: assert property ((sel && !(wr_ev && wofs == OFS_CTRL)) |=> !cc[C_START])
        else $error("start bit not cleared at bus access");
    a_error_halts: assert property (err |=> st_r == E_IDLE && done_r[cur_r] && bes_r[cur_r])
        else $error("bus error did not halt channel");
    a_gap_release: assert property (go_gap |=> !dbus_breq ##1 !dbus_breq ##1 st_r == E_ARB)
        else $error("bus not released then re-requested at boundary");
    a_single_count: assert property ((st_r == E_SGL && ok) |=> bcr_cur == $past(nbcr))
        else $error("single access count not decremented");
    a_steal_once: assert property ((fin && cc[C_CS]) |=> st_r == E_IDLE)
        else $error("cycle steal ran more than one transfer");
    a_ext_gated: assert property ((!ctrl_r[3][C_START] && !ctrl_r[3][C_EXTERNAL_REQUEST_ENABLE]) |-> !rq[3])
        else $error("pin request accepted while disabled");
    a_done_clears: assert property ((sw_clr[0] && !rq[0] && cur_r != 2'h0) |=> !done_r[0] && !bes_r[0] && !ce_r[0])
        else $error("done write did not clear status");
    a_fixed_prio: assert property ((pend_r[0] && !(bw_all[1] == 3'h0 && bw_all[0] != 3'h0)) |-> pk == 3'b100)
        else $error("channel 0 lost arbitration");
    a_read_to_write: assert property ((st_r == E_RD && ok && rem_r == sb) |=> st_r == E_WR && cmd_r.write)
        else $error("read phase did not hand over to write");
    a_done_at_zero: assert property ((fin && nbcr == '0) |=> done_r[cur_r] && st_r == E_IDLE)
        else $error("done not set at zero count");

    c_single_done: cover property (fin && cc[C_SAA] && nbcr == '0);
    c_dual_done: cover property (fin && !cc[C_SAA] && nbcr == '0);
    c_gap: cover property (go_gap);
    c_error: cover property (err);

endmodule

// ---- verilog/dcts_pkg.sv ----
// Package: constants and types shared by the DMA channel sequencer
package dcts_pkg;

    // ==========================================================
    // Channel map: each channel owns a 32-byte register window
    localparam int NCH = 4;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_SAR = 5'h08;
    localparam logic [4:0] OFS_DAR = 5'h0C;
    localparam logic [4:0] OFS_BCR = 5'h10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // ==========================================================
    // Control register fields
    localparam int C_START = 0;
    localparam int C_EXTERNAL_REQUEST_ENABLE = 1;
    localparam int C_CS = 2;
    localparam int C_SAA = 3;
    localparam int C_SOURCE_INCREMENT_ENABLE = 4;
    localparam int C_DEST_INCREMENT_ENABLE = 5;
    localparam int C_SOURCE_WIDTH_FIELD = 6;
    localparam int C_DEST_WIDTH_FIELD = 8;
    localparam int C_BWC = 10;
    localparam int C_SRW = 13;

    // ==========================================================
    // Status register fields
    localparam int S_DONE = 0;
    localparam int S_ACT = 1;
    localparam int S_REQ = 2;
    localparam int S_BES = 5;
    localparam int S_CE = 6;

    // ==========================================================
    // Access size codes and bandwidth block base (2^(BANDWIDTH_LIMIT_FIELD+base) bytes)
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;
    localparam logic [4:0] BWC_BASE = 5'h09;

    typedef enum logic [2:0] {E_IDLE, E_ARB, E_RD, E_WR, E_SGL, E_GAP} dcts_state_t;

    typedef struct packed {
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dcts_cmd_t;

endpackage

// ---- tb/dcts_bus_model.sv ----
// Partner model: bus arbiter and memory on the DMA side
`timescale 1ns/1ps
module dcts_bus_model #(
    parameter int LAT = 1 // Access waits LAT+1 cycles before ack
)
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic breq, // Bus request
    output logic gnt, // Grant
    input wire logic valid, // Access pending
    input wire dcts_pkg::dcts_cmd_t cmd, // Access command
    output logic [31:0] rdata, // Read data
    output logic ack, // Access done
    output logic err, // Access failed
    output logic [31:0] last_wd // Last written data
);
    import dcts_pkg::*;
    localparam logic [31:0] ERR_ADDR = 32'h0000_F000;
    int cnt;
    // Inverted outside ack so a stale word never passes for data
    assign rdata = ack ? (cmd.addr ^ 32'hA5A5_0000) : ~(cmd.addr ^ 32'hA5A5_0000);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gnt <= 1'b0;
            ack <= 1'b0;
            err <= 1'b0;
            cnt <= 0;
            last_wd <= 32'h0;
        end
        else
        begin
            gnt <= breq;
            ack <= 1'b0;
            err <= 1'b0;
            if (valid && !ack && !err)
            begin
                cnt <= (cnt == LAT) ? 0 : cnt + 1;
                if (cnt == LAT)
                begin
                    err <= (cmd.addr == ERR_ADDR);
                    ack <= (cmd.addr != ERR_ADDR);
                    if (cmd.write)
                        last_wd <= cmd.wdata;
                end
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the DMA channel sequencer
`timescale 1ns/1ps
module testbench;
    import dcts_pkg::*;
    typedef struct {logic [31:0] ch, ctrl, source_addr_reg, dest_addr_reg, byte_count_reg, pin, esar, edar, ebcr, estat, ewd;} dcts_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [3:0] req_n = 4'hF;
    logic hreadyout, hresp, breq, gnt, valid, ack, err;
    logic [31:0] hrdata, rdata, last_wd, rd, b, q;
    logic ce = 1'b1;
    logic breq_q = 1'b0;
    int n_drops = 0;
    dcts_cmd_t cmd;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    dcts_row_t rows [10] = '{
        '{0, 32'h31, 32'h100, 32'h200, 8, 4'hF, 32'h108, 32'h208, 0, 1, 32'hA5A5_0104},
        '{1, 32'h151, 32'h301, 32'h400, 3, 4'hF, 32'h304, 32'h400, 0, 1, 0},
        '{2, 32'hB1, 32'h500, 32'h600, 4, 4'hF, 32'h504, 32'h604, 0, 1, 32'hA5A5_0502},
        '{3, 32'h2099, 32'h700, 32'h800, 4, 4'hF, 32'h704, 32'h800, 0, 1, 0},
        '{0, 32'h3F1, 32'h1000, 32'h2000, 32, 4'hF, 32'h1020, 32'h2020, 0, 1, 0},
        '{1, 32'h35, 32'h100, 32'h200, 8, 4'hF, 32'h104, 32'h204, 4, 0, 0},
        '{2, 32'h32, 32'h100, 32'h200, 8, 4'hB, 32'h108, 32'h208, 0, 1, 0},
        '{3, 32'h30, 32'h100, 32'h200, 8, 4'h7, 32'h100, 32'h200, 8, 0, 0},
        '{0, 32'h31, 32'hF000, 32'h200, 8, 4'hF, 32'hF000, 32'h200, 8, 32'h21, 0},
        '{1, 32'h31, 32'h100, 32'h200, 0, 4'hF, 32'h100, 32'h200, 0, 32'h41, 0}};

    dcts_seq u_dcts_seq (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .external_transfer_request_n(req_n),
        .dbus_breq(breq), .dbus_gnt(gnt), .dbus_valid(valid), .dbus_cmd(cmd), .dbus_rdata(rdata),
        .dbus_ack(ack), .dbus_err(err));
    dcts_bus_model #(.LAT(2)) u_dcts_bus_model (.hclk(hclk), .hresetn(hresetn), .breq(breq), .gnt(gnt),
        .valid(valid), .cmd(cmd), .rdata(rdata), .ack(ack), .err(err), .last_wd(last_wd));

    always #2 hclk = ~hclk;

    // =========================================================
    // Bus tasks
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    // Each release of the bus request is one fall, sampled away from the launching edge
    always @(negedge hclk)
    begin
        breq_q <= breq;
        if (breq_q && !breq)
            n_drops <= n_drops + 1;
    end

    // =========================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge hclk);
        chk({29'h0, hreadyout, breq, valid}, 32'h4);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i])
        begin
            b = rows[i].ch << 5;
            ahb(1'b1, b + OFS_SAR, rows[i].source_addr_reg);
            ahb(1'b1, b + OFS_DAR, rows[i].dest_addr_reg);
            ahb(1'b1, b + OFS_BCR, rows[i].byte_count_reg);
            ahb(1'b1, b + OFS_CTRL, rows[i].ctrl);
            req_n <= rows[i].pin[3:0];
            repeat (80) @(posedge hclk);
            req_n <= 4'hF;
            rdchk(b + OFS_SAR, rows[i].esar);
            rdchk(b + OFS_DAR, rows[i].edar);
            rdchk(b + OFS_BCR, rows[i].ebcr);
            rdchk(b + OFS_STAT, rows[i].estat);
            rdchk(b + OFS_CTRL, rows[i].ctrl & ~32'h1);
            if (rows[i].ewd != 32'h0)
                chk(last_wd, rows[i].ewd);
            ahb(1'b1, b + OFS_STAT, 32'h1);
            rdchk(b + OFS_STAT, 32'h0);
        end
        rdchk(32'h80, 32'h0);
        // Both pins fall together; channel 0 wins, then bandwidth zero on channel 1 beats a bandwidth-limited channel 0
        for (int k = 0; k < 2; k++)
        begin
            for (int c = 0; c < 2; c++)
            begin
                ahb(1'b1, c * 32 + OFS_SAR, 32'h100 + c * 32'h200);
                ahb(1'b1, c * 32 + OFS_BCR, 32'h4);
                ahb(1'b1, c * 32 + OFS_CTRL, (c == 0 && k == 1) ? 32'h402 : 32'h2);
            end
            req_n <= 4'hC;
            @(negedge hclk);
            while (valid !== 1'b1) @(negedge hclk);
            chk(cmd.addr, k ? 32'h300 : 32'h100);
            @(posedge hclk);
            repeat (40) @(posedge hclk);
            req_n <= 4'hF;
            ahb(1'b1, OFS_STAT, 32'h1);
            ahb(1'b1, 32'h20 + OFS_STAT, 32'h1);
        end
        // Long line-size run with the smallest bandwidth block: one forced gap, plus a frozen stretch
        b = n_drops;
        ahb(1'b1, 32'h40 + OFS_SAR, 32'h1000);
        ahb(1'b1, 32'h40 + OFS_DAR, 32'h4000);
        ahb(1'b1, 32'h40 + OFS_BCR, 32'h800);
        ahb(1'b1, 32'h40 + OFS_CTRL, 32'h7F1);
        repeat (100) @(posedge hclk);
        ce <= 1'b0;
        @(negedge hclk);
        q = cmd.addr;
        repeat (20) @(negedge hclk);
        chk(cmd.addr, q);
        @(posedge hclk);
        ce <= 1'b1;
        repeat (1200) @(posedge hclk);
        chk(n_drops - b, 32'h2);
        rdchk(32'h40 + OFS_SAR, 32'h1800);
        rdchk(32'h40 + OFS_DAR, 32'h4800);
        rdchk(32'h40 + OFS_BCR, 32'h0);
        rdchk(32'h40 + OFS_STAT, 32'h1);
        conclude();
    end
endmodule
